// >>> testbench/isl_bus_master.sv
`default_nettype none
module isl_bus_master (
  // clock
  input wire logic clock,
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // pull-downs of the master
  output var logic scl_low,
  output var logic sda_low,
  // waits that ran out
  output var int stall_err
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 5;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stall_err = 0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  // master makes the clock but waits while the slave stretches it
  task automatic rise_scl();
    int i;
    i = 0;
    scl_low <= 1'b0;
    @(posedge clock);
    while (scl !== 1'b1 && i < 4000) begin
      @(posedge clock);
      i++;
    end
    if (i == 4000) stall_err++;
  endtask
  task automatic send_start();
    sda_low <= 1'b0;
    rise_scl();
    idle(Q);
    sda_low <= 1'b1;
    idle(Q);
    scl_low <= 1'b1;
  endtask
  task automatic clock_bit(input logic b, output logic seen);
    idle(Q);
    sda_low <= !b;
    idle(Q);
    rise_scl();
    idle(Q);
    seen = sda;
    idle(Q);
    scl_low <= 1'b1;
  endtask
  task automatic write_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) clock_bit(v[k], s);
    clock_bit(1'b1, ack);
  endtask
  task automatic read_byte(input logic ack, output logic [7:0] v);
    logic s;
    for (int k = 7; k >= 0; k--) clock_bit(1'b1, v[k]);
    clock_bit(ack, s);
  endtask
  task automatic send_stop();
    idle(Q);
    sda_low <= 1'b1;
    idle(Q);
    rise_scl();
    idle(Q);
    sda_low <= 1'b0;
    idle(2 * Q);
  endtask
  // short low pulse on the data line
  task automatic glitch(input int n);
    sda_low <= 1'b1;
    idle(n);
    sda_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/isl_slave_tb.sv
`include "isl_consts.svh"
`default_nettype none
module isl_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] C0 = `ISL_OFF_CONTROL0;
  localparam logic [2:0] SC = `ISL_OFF_STATUS_CONTROL;
  localparam logic [2:0] DB = `ISL_OFF_DATA_BUFFER;
  localparam logic [2:0] AS = `ISL_OFF_ADDRESS_STORE;
  localparam logic [2:0] TO = `ISL_OFF_TIMEOUT_CONTROL;
  localparam logic [7:0] MODES [8] = '{8'h02, 8'h22, 8'h42, 8'h62,
    8'h82, 8'ha2, 8'he2, 8'hc0};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, transfer_event;
  logic scl_low, sda_low, scl_line, sda_line;
  int miscompares = 0;
  int n_compared = 0;
  int events = 0;
  int stall_err;
  // open drain with pull-ups
  assign scl_line = !(scl_low === 1'b1 || scl_oe === 1'b1);
  assign sda_line = !(sda_low === 1'b1 || sda_oe === 1'b1);
  always #4 clock = ~clock;
  isl_slave #(.SUB_CYCLES(4)) u_isl_slave (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .transfer_event(transfer_event));
  isl_bus_master u_isl_bus_master (.clock(clock), .scl(scl_line),
    .sda(sda_line), .scl_low(scl_low), .sda_low(sda_low),
    .stall_err(stall_err));
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic reg_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    check($sformatf("register %0d", a), d, e);
  endtask
  task automatic wait_oe(input logic want);
    int i;
    i = 0;
    while (scl_oe !== want && i < 400) begin
      @(posedge clock);
      i++;
    end
    if (i == 400) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  always @(posedge clock) if (transfer_event === 1'b1) events++;
  // lines are only ever pulled low
  always @(posedge clock) if (rst_n === 1'b1)
    check("line level", {6'h0, scl_out, sda_out}, 8'h00);
  initial begin
    #700us;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] d;
    logic ack;
    int ev;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    check("oe at reset", {6'h0, scl_oe, sda_oe}, 8'h00);
    reg_chk(C0, 8'he0);
    reg_chk(SC, 8'h81);
    reg_chk(AS, 8'h00);
    reg_chk(TO, 8'h00);
    reg_wr(3'h5, 8'hff);
    reg_chk(3'h5, 8'h00);
    reg_wr(C0, 8'hff);
    reg_chk(C0, 8'hef);
    reg_wr(SC, 8'hff);
    reg_chk(SC, 8'h9b);
    reg_wr(SC, 8'h00);
    reg_wr(AS, 8'ha5);
    reg_chk(AS, 8'ha5);
    // every mode but two-wire slave, and disabled two-wire: no answer
    for (int m = 0; m < 8; m++) begin
      reg_wr(C0, MODES[m]);
      u_isl_bus_master.send_start();
      u_isl_bus_master.write_byte(8'ha4, ack);
      check("ack off mode", {7'h0, ack}, 8'h01);
      u_isl_bus_master.send_stop();
    end
    // master writes one byte under each debounce code
    for (int db = 0; db < 4; db++) begin
      reg_wr(C0, {3'h6, 1'b0, db[1:0], 2'b10});
      ev = events;
      u_isl_bus_master.send_start();
      u_isl_bus_master.write_byte(8'ha4, ack);
      check("address ack", {7'h0, ack}, 8'h00);
      wait_oe(1'b1);
      reg_chk(SC, 8'he1);
      reg_rd(DB, d);
      wait_oe(1'b0);
      u_isl_bus_master.write_byte(8'h3c + 8'(db), ack);
      check("data ack", {7'h0, ack}, 8'h00);
      wait_oe(1'b1);
      reg_chk(SC, 8'ha1);
      reg_chk(DB, 8'h3c + 8'(db));
      u_isl_bus_master.send_stop();
      // stop clock rise after the release opens a byte: done flag drops low
      reg_chk(SC, 8'h01);
      check("events", 8'(events - ev), 8'h02);
    end
    // short pulse shorter than the four clock filter
    reg_wr(C0, 8'hca);
    u_isl_bus_master.glitch(3);
    repeat (20) @(posedge clock);
    reg_chk(SC, 8'h01);
    // refuse a byte with ack_to_send set
    reg_wr(SC, 8'h08);
    u_isl_bus_master.send_start();
    u_isl_bus_master.write_byte(8'ha4, ack);
    wait_oe(1'b1);
    reg_rd(DB, d);
    wait_oe(1'b0);
    u_isl_bus_master.write_byte(8'h77, ack);
    check("nack sent", {7'h0, ack}, 8'h01);
    repeat (20) @(posedge clock);
    check("no stretch", {7'h0, scl_oe}, 8'h00);
    u_isl_bus_master.send_stop();
    reg_wr(SC, 8'h00);
    // foreign address
    u_isl_bus_master.send_start();
    u_isl_bus_master.write_byte(8'hb4, ack);
    check("foreign ack", {7'h0, ack}, 8'h01);
    reg_rd(SC, d);
    check("foreign match", {7'h0, d[6]}, 8'h00);
    u_isl_bus_master.send_stop();
    // master reads two bytes, the second refused by the master
    u_isl_bus_master.send_start();
    u_isl_bus_master.write_byte(8'ha5, ack);
    check("read address ack", {7'h0, ack}, 8'h00);
    wait_oe(1'b1);
    reg_chk(SC, 8'he5);
    reg_wr(SC, 8'h10);
    reg_wr(DB, 8'hc5);
    u_isl_bus_master.read_byte(1'b0, d);
    check("read byte", d, 8'hc5);
    wait_oe(1'b1);
    reg_chk(SC, 8'hb4);
    reg_wr(DB, 8'h5a);
    u_isl_bus_master.read_byte(1'b1, d);
    check("read last", d, 8'h5a);
    reg_rd(SC, d);
    check("master nack", {7'h0, d[0]}, 8'h01);
    // re-enable mid transfer keeps tx, ack_to_send and no_internal_clock bits only
    reg_wr(SC, 8'h18);
    reg_wr(C0, 8'hc8);
    @(posedge clock);
    #1;
    check("oe disabled", {6'h0, scl_oe, sda_oe}, 8'h00);
    reg_wr(C0, 8'hca);
    reg_chk(SC, 8'h99);
    u_isl_bus_master.send_stop();
    reg_wr(SC, 8'h00);
    // stretch left hanging until the timeout of 128 clocks
    reg_wr(TO, 8'h80);
    u_isl_bus_master.send_start();
    u_isl_bus_master.write_byte(8'ha4, ack);
    wait_oe(1'b1);
    repeat (100) @(posedge clock);
    reg_chk(TO, 8'h80);
    repeat (40) @(posedge clock);
    reg_chk(TO, 8'hc0);
    check("oe after timeout", {7'h0, scl_oe}, 8'h00);
    reg_wr(TO, 8'h00);
    reg_chk(TO, 8'h00);
    u_isl_bus_master.send_stop();
    check("stalls", 8'(stall_err), 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> verilog/isl_consts.svh
`ifndef ISL_CONSTS_SVH
`define ISL_CONSTS_SVH

// register offsets on the plain register port
`define ISL_ADDR_W 3
`define ISL_OFF_CONTROL0 3'h0
`define ISL_OFF_STATUS_CONTROL 3'h1
`define ISL_OFF_DATA_BUFFER 3'h2
`define ISL_OFF_ADDRESS_STORE 3'h3
`define ISL_OFF_SPI_CONTROL_ALIAS 3'h3
`define ISL_OFF_TIMEOUT_CONTROL 3'h4

// module mode codes
`define ISL_MODE_SPI_SLAVE 3'h5
`define ISL_MODE_I2C_SLAVE 3'h6
`define ISL_MODE_UNUSED 3'h7

// debounce codes and lengths in system clocks
`define ISL_DBNC_OFF 2'h0
`define ISL_DBNC_TWO 2'h1
`define ISL_DBNC_LEN_OFF 3'h0
`define ISL_DBNC_LEN_TWO 3'h2
`define ISL_DBNC_LEN_FOUR 3'h4

// control0 fields
`define ISL_C0_MODE_HI 7
`define ISL_C0_MODE_LO 5
`define ISL_C0_DBNC_HI 3
`define ISL_C0_DBNC_LO 2
`define ISL_C0_ENABLE 1
`define ISL_C0_INCOMPLETE 0

// status/control fields
`define ISL_SC_BYTE_DONE 7
`define ISL_SC_ADDR_MATCH 6
`define ISL_SC_BUS_BUSY 5
`define ISL_SC_TX_SELECT 4
`define ISL_SC_ACK_TO_SEND 3
`define ISL_SC_RW_CAPTURE 2
`define ISL_SC_NO_INT_CLK 1
`define ISL_SC_RX_ACK 0

// timeout control fields
`define ISL_TO_ENABLE 7
`define ISL_TO_FLAG 6
`define ISL_TO_SEL_HI 5
`define ISL_TO_SEL_LO 0

// reset values
`define ISL_RST_MODE 3'h7
`define ISL_RST_BYTE_DONE 1'h1
`define ISL_RST_RX_ACK 1'h1

// bit counts
`define ISL_BYTE_BITS 4'h8
`define ISL_TO_SUB_SHIFT 5

// timing: sub clock period and system clock period in ns
`define ISL_SUB_PERIOD_NS 32000
`define ISL_CLK_PERIOD_NS 8
`define ISL_SUB_CYCLES (`ISL_SUB_PERIOD_NS / `ISL_CLK_PERIOD_NS)

`endif

// >>> verilog/isl_pkg.sv
`default_nettype none
package isl_pkg;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_ack_addr,
    st_hold,
    st_rx,
    st_ack_rx,
    st_tx,
    st_ack_tx,
    st_wait
  } isl_state_t;

endpackage
`default_nettype wire

// >>> verilog/isl_slave.sv
`include "isl_consts.svh"
`default_nettype none
module isl_slave
  import isl_pkg::*;
#(
  parameter int unsigned SUB_CYCLES = `ISL_SUB_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [`ISL_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // bus clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // bus data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // event pulse
  output logic transfer_event
);

  // software registers
  logic [2:0] module_mode_select;
  logic [1:0] debounce_select;
  logic module_enable;
  logic incomplete_transfer_flag;
  logic byte_complete_flag;
  logic address_match_flag;
  logic bus_busy_flag;
  logic transmit_select;
  logic ack_to_send;
  logic read_write_capture;
  logic no_internal_clock;
  logic received_ack_flag;
  logic [7:0] serial_data_buffer;
  logic [7:0] slave_address_store;
  logic timeout_enable;
  logic timeout_flag;
  logic [5:0] timeout_period_select;

  // engine state
  isl_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic enable_d;
  logic [15:0] sub_cnt;
  logic [11:0] to_cnt;

  logic wr_c0, wr_sc, wr_data, wr_addr, wr_to, buf_touch;
  logic active, en_rise;
  logic [1:0] line_in, filt, filt_d;
  logic [2:0] need;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic addr_done, match, rx_done, tx_done, ack_sample, byte_begin;
  logic to_run, to_hit;
  logic [6:0] sel_plus1;
  logic [11:0] to_limit;
  logic [7:0] tx_src;

  assign wr_c0 = reg_write && reg_addr == `ISL_OFF_CONTROL0;
  assign wr_sc = reg_write && reg_addr == `ISL_OFF_STATUS_CONTROL;
  assign wr_data = reg_write && reg_addr == `ISL_OFF_DATA_BUFFER;
  assign wr_addr = reg_write && reg_addr == `ISL_OFF_ADDRESS_STORE;
  assign wr_to = reg_write && reg_addr == `ISL_OFF_TIMEOUT_CONTROL;
  assign buf_touch = (reg_read || reg_write)
                     && reg_addr == `ISL_OFF_DATA_BUFFER;

  assign active = module_enable
                  && module_mode_select == `ISL_MODE_I2C_SLAVE;
  assign en_rise = module_enable && !enable_d
                   && module_mode_select == `ISL_MODE_I2C_SLAVE;

  // software-only control bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      module_mode_select <= `ISL_RST_MODE;
      debounce_select <= 2'h0;
      module_enable <= 1'b0;
      incomplete_transfer_flag <= 1'b0;
      transmit_select <= 1'b0;
      ack_to_send <= 1'b0;
      no_internal_clock <= 1'b0;
      slave_address_store <= 8'h00;
      timeout_enable <= 1'b0;
      timeout_period_select <= 6'h00;
    end else begin
      if (wr_c0) begin
        module_mode_select <= reg_wdata[`ISL_C0_MODE_HI:`ISL_C0_MODE_LO];
        debounce_select <= reg_wdata[`ISL_C0_DBNC_HI:`ISL_C0_DBNC_LO];
        module_enable <= reg_wdata[`ISL_C0_ENABLE];
        incomplete_transfer_flag <= reg_wdata[`ISL_C0_INCOMPLETE];
      end
      if (wr_sc) begin
        transmit_select <= reg_wdata[`ISL_SC_TX_SELECT];
        ack_to_send <= reg_wdata[`ISL_SC_ACK_TO_SEND];
        no_internal_clock <= reg_wdata[`ISL_SC_NO_INT_CLK];
      end
      if (wr_addr) begin
        slave_address_store <= reg_wdata;
      end
      if (wr_to) begin
        timeout_enable <= reg_wdata[`ISL_TO_ENABLE];
        timeout_period_select <= reg_wdata[`ISL_TO_SEL_HI:`ISL_TO_SEL_LO];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_d <= 1'b0;
    end else begin
      enable_d <= module_enable;
    end
  end

  // line sampling and debounce, index 0 clock line, 1 data line
  assign line_in = {sda_in, scl_in};
  always_comb begin
    if (debounce_select == `ISL_DBNC_OFF) begin
      need = `ISL_DBNC_LEN_OFF;
    end else if (debounce_select == `ISL_DBNC_TWO) begin
      need = `ISL_DBNC_LEN_TWO;
    end else begin
      need = `ISL_DBNC_LEN_FOUR;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic s1, s2, f, fd;
      logic [2:0] stab;
      assign filt[g] = f;
      assign filt_d[g] = fd;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
        end else begin
          s1 <= line_in[g];
          s2 <= s1;
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          f <= 1'b1;
          fd <= 1'b1;
          stab <= 3'h0;
        end else begin
          fd <= f;
          if (s2 == f) begin
            stab <= 3'h0;
          end else if (3'(stab + 3'h1) >= need) begin
            f <= s2;
            stab <= 3'h0;
          end else begin
            stab <= 3'(stab + 3'h1);
          end
        end
      end
    end
  endgenerate

  assign scl_rise = filt[0] && !filt_d[0];
  assign scl_fall = !filt[0] && filt_d[0];
  assign start_ev = !filt[1] && filt_d[1] && filt[0] && filt_d[0];
  assign stop_ev = filt[1] && !filt_d[1] && filt[0] && filt_d[0];

  assign match = shreg[7:1] == slave_address_store[7:1];
  assign addr_done = state == st_addr && scl_fall
                     && bit_cnt == `ISL_BYTE_BITS;
  assign rx_done = state == st_rx && scl_fall && bit_cnt == `ISL_BYTE_BITS;
  assign tx_done = state == st_tx && scl_fall && bit_cnt == `ISL_BYTE_BITS;
  assign ack_sample = state == st_ack_tx && scl_rise;
  assign byte_begin = (state == st_rx || state == st_tx) && scl_rise
                      && bit_cnt == 4'h0;
  assign tx_src = wr_data ? reg_wdata : serial_data_buffer;

  // bit engine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (!active || to_hit) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (start_ev) begin
      state <= st_addr;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop_ev) begin
      state <= st_idle;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      case (state)
        st_addr, st_rx: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], filt[1]};
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (scl_fall && bit_cnt == `ISL_BYTE_BITS) begin
            if (state == st_rx) begin
              sda_oe <= !ack_to_send;
              state <= st_ack_rx;
            end else if (match) begin
              sda_oe <= 1'b1;
              state <= st_ack_addr;
            end else begin
              state <= st_wait;
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b1;
            state <= st_hold;
          end
        end
        st_ack_rx: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            scl_oe <= !ack_to_send;
            state <= ack_to_send ? st_wait : st_hold;
          end
        end
        st_hold: begin
          if (buf_touch) begin
            scl_oe <= 1'b0;
            bit_cnt <= 4'h0;
            if (transmit_select) begin
              shreg <= tx_src;
              sda_oe <= !tx_src[7];
              state <= st_tx;
            end else begin
              sda_oe <= 1'b0;
              state <= st_rx;
            end
          end
        end
        st_tx: begin
          if (scl_rise) begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
          end else if (scl_fall) begin
            if (bit_cnt == `ISL_BYTE_BITS) begin
              sda_oe <= 1'b0;
              state <= st_ack_tx;
            end else begin
              sda_oe <= !shreg[6];
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
        st_ack_tx: begin
          if (scl_fall) begin
            scl_oe <= !received_ack_flag;
            state <= received_ack_flag ? st_wait : st_hold;
          end
        end
        st_idle, st_wait: begin
          state <= state;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // open-drain: only ever pull low, master owns the clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // shared data buffer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_buffer <= 8'h00;
    end else if (rx_done && active) begin
      serial_data_buffer <= shreg;
    end else if (wr_data) begin
      serial_data_buffer <= reg_wdata;
    end
  end

  // status flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      byte_complete_flag <= `ISL_RST_BYTE_DONE;
      address_match_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      read_write_capture <= 1'b0;
      received_ack_flag <= `ISL_RST_RX_ACK;
    end else if (en_rise) begin
      byte_complete_flag <= `ISL_RST_BYTE_DONE;
      address_match_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      read_write_capture <= 1'b0;
      received_ack_flag <= `ISL_RST_RX_ACK;
    end else if (active) begin
      if (start_ev) begin
        bus_busy_flag <= 1'b1;
      end else if (stop_ev) begin
        bus_busy_flag <= 1'b0;
      end
      if (addr_done) begin
        address_match_flag <= match;
        byte_complete_flag <= match;
        if (match) begin
          read_write_capture <= shreg[0];
        end
      end else if (rx_done || tx_done) begin
        byte_complete_flag <= 1'b1;
      end else if (byte_begin || start_ev) begin
        byte_complete_flag <= 1'b0;
        address_match_flag <= 1'b0;
      end
      if (ack_sample) begin
        received_ack_flag <= filt[1];
      end
    end
  end

  // bus timeout
  assign sel_plus1 = 7'({1'b0, timeout_period_select} + 7'h1);
  assign to_limit = {sel_plus1, 5'h00};
  assign to_run = active && timeout_enable && state != st_idle;
  assign to_hit = to_run && to_cnt == to_limit;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sub_cnt <= 16'h0000;
      to_cnt <= 12'h000;
    end else if (!to_run || scl_rise || scl_fall) begin
      sub_cnt <= 16'h0000;
      to_cnt <= 12'h000;
    end else if (sub_cnt == 16'(SUB_CYCLES - 1)) begin
      sub_cnt <= 16'h0000;
      to_cnt <= 12'(to_cnt + 12'h001);
    end else begin
      sub_cnt <= 16'(sub_cnt + 16'h0001);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag <= 1'b0;
    end else if (to_hit) begin
      timeout_flag <= 1'b1;
    end else if (wr_to) begin
      timeout_flag <= reg_wdata[`ISL_TO_FLAG];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transfer_event <= 1'b0;
    end else begin
      transfer_event <= active
                        && ((addr_done && match) || rx_done || tx_done
                            || to_hit);
    end
  end

  // register read, data valid the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ISL_OFF_CONTROL0:
          reg_rdata <= {module_mode_select, 1'b0, debounce_select,
                        module_enable, incomplete_transfer_flag};
        `ISL_OFF_STATUS_CONTROL:
          reg_rdata <= {byte_complete_flag, address_match_flag,
                        bus_busy_flag, transmit_select, ack_to_send,
                        read_write_capture, no_internal_clock,
                        received_ack_flag};
        `ISL_OFF_DATA_BUFFER:
          reg_rdata <= serial_data_buffer;
        `ISL_OFF_ADDRESS_STORE:
          reg_rdata <= slave_address_store;
        `ISL_OFF_TIMEOUT_CONTROL:
          reg_rdata <= {timeout_enable, timeout_flag, timeout_period_select};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks
  lines_float_a: assert property (@(posedge clock) disable iff (!rst_n)
    !active |=> !sda_oe && !scl_oe)
    else $error("lines driven while interface is off");

  busy_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && start_ev && !en_rise |=> bus_busy_flag)
    else $error("busy flag not set on start");

  busy_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && stop_ev && !start_ev && !en_rise |=> !bus_busy_flag)
    else $error("busy flag not cleared on stop");

  enable_flags_a: assert property (@(posedge clock) disable iff (!rst_n)
    en_rise |=> byte_complete_flag && !address_match_flag
                && !bus_busy_flag && received_ack_flag)
    else $error("flags not restored on enable");

  addr_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && !to_hit && !start_ev && !stop_ev && addr_done && match
    |=> sda_oe && address_match_flag)
    else $error("no ack after address match");

  rx_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && !to_hit && !start_ev && !stop_ev && rx_done
    |=> sda_oe == !$past(ack_to_send) && byte_complete_flag)
    else $error("receive ack level wrong");

  rx_ack_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && ack_sample && !en_rise
    |=> received_ack_flag == $past(filt[1]))
    else $error("received ack not captured");

  byte_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    active && byte_begin && !en_rise |=> !byte_complete_flag)
    else $error("byte flag high during a byte");

  timeout_set_a: assert property (@(posedge clock) disable iff (!rst_n)
    to_hit |=> timeout_flag && state == st_idle && !scl_oe)
    else $error("timeout not taken");

  mode_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    module_mode_select != `ISL_MODE_I2C_SLAVE |=> !sda_oe ##1 !sda_oe)
    else $error("data line driven outside two-wire mode");

endmodule
`default_nettype wire
